// File: inc/dctrf_pkg.sv
// shared constants and types of the temperature result formatter
package dctrf_pkg;
  localparam logic [7:0] ADDR_LOCAL     = 8'h00;
  localparam logic [7:0] ADDR_REM_INT   = 8'h01;
  localparam logic [7:0] ADDR_REM_FRAC  = 8'h10;
  localparam logic [7:0] RESULT_RESET   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
  localparam int         RAW_W          = 12;
  localparam int         FRAC_LSB       = 6;
  localparam logic [3:0] RATE_NO_AVG    = 4'h8;
  localparam int         AVG_COUNT      = 16;
  localparam int         AVG_SHIFT      = 4;
  localparam logic signed [10:0] EXT_OFFSET = 11'sh040;
  localparam logic signed [10:0] EXT_MAX    = 11'sh0ff;
  localparam logic signed [10:0] PLAIN_MAX  = 11'sh07f;
  localparam logic [7:0] OFFSET_ZERO    = 8'h40;

  typedef enum logic [1:0] {
    CUR_BASE_A,
    CUR_MULT1,
    CUR_BASE_B,
    CUR_MULT2
  } dctrf_step_type;

  typedef enum logic {
    CH_LOCAL,
    CH_REMOTE
  } dctrf_chan_type;

  // raw temperature is signed, quarter degree per count
  typedef struct packed {
    dctrf_chan_type          chan;
    logic                    rangeExt;
    logic                    diodeShort;
    logic signed [RAW_W-1:0] temp;
  } dctrf_sample_type;

  typedef struct packed {
    logic       read;
    logic [7:0] addr;
  } dctrf_rdreq_type;
endpackage

// File: verilog/dctrf_sequencer.sv
// current step and channel sequencer for the diode front end
`timescale 1ns/1ps
`default_nettype none
module dctrf_sequencer
  import dctrf_pkg::*;
(
  // clock and reset
  input  wire logic     clock,
  input  wire logic     sys_rst,
  // control
  input  wire logic     stepDone,
  input  wire logic     rangeSelect,
  // sequence state
  output dctrf_step_type step,
  output dctrf_chan_type chan,
  output logic           rangeLatched
);
  dctrf_step_type next_step;
  dctrf_chan_type next_chan;
  logic           next_rangeLatched;

  always_comb begin
    next_step = step;
    next_chan = chan;
    next_rangeLatched = rangeLatched;
    if (stepDone) begin
      unique case (step)
        CUR_BASE_A: next_step = CUR_MULT1; // RULE_01
        CUR_MULT1:  next_step = CUR_BASE_B; // RULE_01
        CUR_BASE_B: next_step = CUR_MULT2; // RULE_01
        CUR_MULT2: begin
          next_step = CUR_BASE_A;
          // alternate channels, free running
          next_chan = (chan == CH_LOCAL) ? CH_REMOTE : CH_LOCAL; // RULE_17
          // range taken once per conversion start
          next_rangeLatched = rangeSelect; // RULE_18 RULE_11
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      step <= CUR_BASE_A;
      chan <= CH_LOCAL;
      rangeLatched <= 1'b0;
    end else begin
      step <= next_step;
      chan <= next_chan;
      rangeLatched <= next_rangeLatched;
    end
  end
endmodule
`default_nettype wire

// File: verilog/dctrf_averager.sv
// per channel sixteen sample averager with bypass
`timescale 1ns/1ps
`default_nettype none
module dctrf_averager
  import dctrf_pkg::*;
#(
  parameter int COUNT = AVG_COUNT,
  parameter int SHIFT = AVG_SHIFT
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // raw samples
  input  wire logic              inValid,
  input  wire dctrf_sample_type  inSample,
  input  wire logic              avgOn,
  // results
  output logic                   outValid,
  output dctrf_sample_type       outSample
);
  localparam int ACC_W = RAW_W + SHIFT;
  logic signed [ACC_W-1:0] acc [2];
  logic [SHIFT-1:0]        cnt [2];
  logic signed [ACC_W-1:0] next_acc [2];
  logic [SHIFT-1:0]        next_cnt [2];
  logic                    next_outValid;
  dctrf_sample_type        next_outSample;

  always_comb begin
    logic signed [ACC_W-1:0] sum;
    int c;
    sum = '0;
    c = int'(inSample.chan);
    next_acc = acc;
    next_cnt = cnt;
    next_outValid = 1'b0;
    next_outSample = outSample;
    // leaving averaging drops partial sums, no stale mix later
    if (!avgOn) begin
      next_acc[0] = '0;
      next_acc[1] = '0;
      next_cnt[0] = '0;
      next_cnt[1] = '0;
    end
    if (inValid) begin
      if (!avgOn || inSample.diodeShort) begin
        next_outValid = 1'b1; // RULE_03
        next_outSample = inSample; // RULE_03
      end else begin
        sum = acc[c] + {{SHIFT{inSample.temp[RAW_W-1]}}, inSample.temp};
        if (cnt[c] == SHIFT'(COUNT - 1)) begin
          next_outValid = 1'b1; // RULE_02
          next_outSample = inSample;
          next_outSample.temp = RAW_W'(sum >>> SHIFT); // RULE_02
          next_acc[c] = '0;
          next_cnt[c] = '0;
        end else begin
          next_acc[c] = sum; // RULE_02
          next_cnt[c] = cnt[c] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc[0] <= '0;
      acc[1] <= '0;
      cnt[0] <= '0;
      cnt[1] <= '0;
      outValid <= 1'b0;
      outSample <= '0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      outValid <= next_outValid;
      outSample <= next_outSample;
    end
  end
endmodule
`default_nettype wire

// File: verilog/dctrf_result_formatter.sv
// temperature result formatter top: sync, sequence, average, registers
// Operation
// (RULE_01) remote: base/first multiple, then base/second multiple
// (RULE_02) slow rates report sixteen-sample averages
// (RULE_03) sixteen per second and faster: no averaging
// (RULE_04) local result byte at 0x00, one degree
// (RULE_05) remote integer at 0x01, fraction at 0x10
// (RULE_06) fraction uses two top bits, rest zero
// (RULE_07) fraction bits 7:6 count quarter degrees
// (RULE_08) fraction read locks integer until read
// (RULE_09) default range 0 to 127, extended available
// (RULE_10) range bit one selects extended range
// (RULE_11) new range valid from next measurement
// (RULE_12) shorted diode keeps last good remote result
// (RULE_13) plain binary default, offset binary extended
// (RULE_14) offset binary adds 64 degrees
// (RULE_15) plain binary clamps to 0 and 127
// (RULE_16) range change leaves limit registers alone
// (RULE_17) free run alternating local and remote
// (RULE_18) range sampled at each conversion start
// (RULE_19) integer read unlocks; next update writes both
`timescale 1ns/1ps
`default_nettype none
module dctrf_result_formatter
  import dctrf_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // configuration
  input  wire logic             rangeSelect,
  input  wire logic [3:0]       convRateCode,
  // analog front end
  input  wire logic             feStepToggle,
  input  wire logic [RAW_W-1:0] feRawTemp,
  input  wire logic             feDiodeShort,
  output dctrf_step_type        currentStep,
  output dctrf_chan_type        measChannel,
  // register read port
  input  wire dctrf_rdreq_type  regReq,
  output logic [7:0]            regReadData
);
  // front end crossing: toggle through three stages, data through two
  logic             tog1;
  logic             tog2;
  logic             tog3;
  logic [RAW_W-1:0] raw1;
  logic [RAW_W-1:0] raw2;
  logic             short1;
  logic             short2;
  logic             stepDone;
  logic             rangeLatched;
  logic             convEnd;
  logic             avgOn;
  dctrf_sample_type sample;
  logic             avgValid;
  dctrf_sample_type avgSample;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tog1 <= 1'b0;
      tog2 <= 1'b0;
      tog3 <= 1'b0;
      raw1 <= '0;
      raw2 <= '0;
      short1 <= 1'b0;
      short2 <= 1'b0;
    end else begin
      tog1 <= feStepToggle;
      tog2 <= tog1;
      tog3 <= tog2;
      raw1 <= feRawTemp;
      raw2 <= raw1;
      short1 <= feDiodeShort;
      short2 <= short1;
    end
  end

  // data settles with the toggle, so it is stable once tog2 moves
  assign stepDone = tog2 ^ tog3;
  assign convEnd = stepDone && (currentStep == CUR_MULT2);
  assign avgOn = convRateCode < RATE_NO_AVG; // RULE_02 RULE_03

  always_comb begin
    sample.chan = measChannel;
    sample.rangeExt = rangeLatched;
    sample.diodeShort = (measChannel == CH_REMOTE) && short2;
    sample.temp = raw2;
  end

  dctrf_sequencer u_seq (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .stepDone     (stepDone),
    .rangeSelect  (rangeSelect),
    .step         (currentStep),
    .chan         (measChannel),
    .rangeLatched (rangeLatched)
  );

  dctrf_averager #(
    .COUNT (AVG_COUNT),
    .SHIFT (AVG_SHIFT)
  ) u_avg (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .inValid   (convEnd),
    .inSample  (sample),
    .avgOn     (avgOn),
    .outValid  (avgValid),
    .outSample (avgSample)
  );

  // integer byte and quarter-degree fraction of one result
  function automatic logic [9:0] formatTemp(
    input logic signed [RAW_W-1:0] t,
    input logic                    ext
  );
    logic signed [10:0] whole;
    logic signed [10:0] shifted;
    whole = 11'(t >>> 2);
    shifted = whole + EXT_OFFSET; // RULE_14
    if (ext) begin
      // offset binary for extended range
      if (shifted < 0) begin
        formatTemp = '0; // RULE_13
      end else if (shifted > EXT_MAX) begin
        formatTemp = {8'hff, 2'h0};
      end else begin
        formatTemp = {shifted[7:0], t[1:0]}; // RULE_13 RULE_10
      end
    end else begin
      // plain binary, 0 to 127 only
      if (whole < 0) begin
        formatTemp = '0; // RULE_15 RULE_09
      end else if (whole > PLAIN_MAX) begin
        formatTemp = {PLAIN_MAX[7:0], 2'h0}; // RULE_15 RULE_09
      end else begin
        formatTemp = {whole[7:0], t[1:0]}; // RULE_13
      end
    end
  endfunction

  // result registers and coherency lock
  logic [7:0] localTemp;
  logic [7:0] remoteInt;
  logic [7:0] remoteFrac;
  logic       locked;
  logic [7:0] next_localTemp;
  logic [7:0] next_remoteInt;
  logic [7:0] next_remoteFrac;
  logic       next_locked;
  logic [7:0] next_regReadData;
  logic       readFrac;
  logic       readInt;

  assign readFrac = regReq.read && (regReq.addr == ADDR_REM_FRAC);
  assign readInt = regReq.read && (regReq.addr == ADDR_REM_INT);

  always_comb begin
    logic [9:0] fmt;
    fmt = formatTemp(avgSample.temp, avgSample.rangeExt);
    next_localTemp = localTemp;
    next_remoteInt = remoteInt;
    next_remoteFrac = remoteFrac;
    next_locked = locked;
    next_regReadData = regReadData;
    // range change touches only formatting, never any limit
    if (avgValid) begin
      if (avgSample.chan == CH_LOCAL) begin
        next_localTemp = fmt[9:2]; // RULE_04 RULE_16
      end else if (!avgSample.diodeShort && !locked && !readFrac) begin // RULE_12 RULE_08
        // both bytes move together, so a pair is always coherent
        next_remoteInt = fmt[9:2]; // RULE_05 RULE_19
        next_remoteFrac = {fmt[1:0], 6'h00}; // RULE_06 RULE_07
      end
      // a shorted diode leaves the last good pair in place
    end
    if (regReq.read) begin
      unique case (regReq.addr)
        ADDR_LOCAL:    next_regReadData = localTemp; // RULE_04
        ADDR_REM_INT:  next_regReadData = remoteInt; // RULE_05
        ADDR_REM_FRAC: next_regReadData = remoteFrac; // RULE_05
        default:       next_regReadData = READ_UNMAPPED;
      endcase
    end
    if (readFrac) begin
      next_locked = 1'b1; // RULE_08
    end else if (readInt) begin
      next_locked = 1'b0; // RULE_19
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      localTemp <= RESULT_RESET;
      remoteInt <= RESULT_RESET;
      remoteFrac <= RESULT_RESET;
      locked <= 1'b0;
      regReadData <= RESULT_RESET;
    end else begin
      localTemp <= next_localTemp;
      remoteInt <= next_remoteInt;
      remoteFrac <= next_remoteFrac;
      locked <= next_locked;
      regReadData <= next_regReadData;
    end
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  chk_step_order: assert property ( // RULE_01
    $changed(currentStep) |->
      (currentStep == CUR_MULT1 && $past(currentStep) == CUR_BASE_A) ||
      (currentStep == CUR_BASE_B && $past(currentStep) == CUR_MULT1) ||
      (currentStep == CUR_MULT2 && $past(currentStep) == CUR_BASE_B) ||
      (currentStep == CUR_BASE_A && $past(currentStep) == CUR_MULT2))
    else $error("current step sequence out of order");

  chk_no_average: assert property ( // RULE_03
    convEnd && !avgOn |=> avgValid && avgSample.temp == $past(raw2))
    else $error("fast rate result was not passed directly");

  chk_local_read: assert property ( // RULE_04
    regReq.read && regReq.addr == ADDR_LOCAL |=>
      regReadData == $past(localTemp))
    else $error("local result read mismatch");

  chk_remint_read: assert property ( // RULE_05
    readInt |=> regReadData == $past(remoteInt))
    else $error("remote integer read mismatch");

  chk_frac_zero: assert property ( // RULE_06
    readFrac |=> regReadData[5:0] == 6'h00)
    else $error("fraction low bits not zero");

  chk_lock_hold: assert property ( // RULE_08
    readFrac ##1 (!readInt)[*2] |-> $stable(remoteInt))
    else $error("locked integer byte changed");

  chk_unlock_update: assert property ( // RULE_19
    readInt && !readFrac |=> !locked)
    else $error("integer read did not release lock");

  chk_short_hold: assert property ( // RULE_12
    avgValid && avgSample.chan == CH_REMOTE && avgSample.diodeShort
      |=> $stable(remoteInt) && $stable(remoteFrac))
    else $error("shorted diode result was stored");

  chk_offset_zero: assert property ( // RULE_14
    avgValid && avgSample.chan == CH_LOCAL && avgSample.rangeExt &&
      avgSample.temp == '0 |=> localTemp == OFFSET_ZERO)
    else $error("zero degrees not stored as offset value");

  chk_plain_clamp: assert property ( // RULE_15
    avgValid && avgSample.chan == CH_LOCAL && !avgSample.rangeExt
      |=> localTemp <= PLAIN_MAX[7:0])
    else $error("plain result above clamp");

  cov_remote_update: cover property (
    avgValid && avgSample.chan == CH_REMOTE && !avgSample.diodeShort);
  cov_locked_pair: cover property (readFrac ##[1:20] readInt);
  cov_averaged: cover property (avgValid && avgOn);
  cov_extended: cover property (avgValid && avgSample.rangeExt);
endmodule
`default_nettype wire

// File: testbench/dctrf_fe_model.sv
// analog front end model: steps the diode currents and serves raw conversions
`timescale 1ns/1ps
`default_nettype none
module dctrf_fe_model
  import dctrf_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // bench control
  input  wire logic             run,
  input  wire logic [RAW_W-1:0] localRaw,
  input  wire logic [RAW_W-1:0] remoteRaw,
  input  wire logic             remoteShort,
  output logic [7:0]            stepCount,
  // front end pins
  input  wire dctrf_chan_type   chan,
  output logic                  feStepToggle,
  output logic [RAW_W-1:0]      feRawTemp,
  output logic                  feDiodeShort
);
  logic [2:0] div;
  // eight clocks a step keeps toggles clear of the sync delay
  always_ff @(posedge clock) begin
    if (sys_rst || !run) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
    if (sys_rst) begin
      feStepToggle <= 1'b0;
      stepCount    <= 8'h00;
    end else if (run && div == 3'h7) begin
      feStepToggle <= !feStepToggle;
      stepCount    <= stepCount + 8'h01;
    end
  end
  // data follows the channel in conversion; a short exists only remotely
  assign feRawTemp    = (chan == CH_LOCAL) ? localRaw : remoteRaw;
  assign feDiodeShort = (chan == CH_REMOTE) && remoteShort;
endmodule
`default_nettype wire

// File: testbench/dctrf_result_formatter_tb.sv
// self-checking bench of the temperature result formatter
`timescale 1ns/1ps
`default_nettype none
module dctrf_result_formatter_tb
  import dctrf_pkg::*;
();
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic             rangeSelect = 1'b0;
  logic [3:0]       convRateCode = RATE_NO_AVG;
  logic             run = 1'b0;
  logic [RAW_W-1:0] localRaw = '0;
  logic [RAW_W-1:0] remoteRaw = '0;
  logic             remoteShort = 1'b0;
  logic [7:0]       stepCount;
  logic             feStepToggle;
  logic [RAW_W-1:0] feRawTemp;
  logic             feDiodeShort;
  dctrf_step_type   currentStep;
  dctrf_chan_type   measChannel;
  dctrf_rdreq_type  regReq = '0;
  logic [7:0]       regReadData;
  dctrf_step_type   prevStep = CUR_BASE_A;
  dctrf_chan_type   prevChan = CH_LOCAL;
  int               numErrors = 0;
  int               cmpCount = 0;

  always #4 clock = !clock;

  dctrf_result_formatter u_dut (
    .clock(clock), .sys_rst(sys_rst), .rangeSelect(rangeSelect),
    .convRateCode(convRateCode), .feStepToggle(feStepToggle), .feRawTemp(feRawTemp),
    .feDiodeShort(feDiodeShort), .currentStep(currentStep), .measChannel(measChannel),
    .regReq(regReq), .regReadData(regReadData));

  dctrf_fe_model u_fe (
    .clock(clock), .sys_rst(sys_rst), .run(run), .localRaw(localRaw),
    .remoteRaw(remoteRaw), .remoteShort(remoteShort), .stepCount(stepCount),
    .chan(measChannel), .feStepToggle(feStepToggle), .feRawTemp(feRawTemp),
    .feDiodeShort(feDiodeShort));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // step order and channel alternation watched all run long
  always @(negedge clock) begin
    if (!sys_rst && currentStep !== prevStep) begin
      chk("step order", 8'(currentStep), 8'(2'(prevStep + 2'h1)));
      if (prevStep == CUR_MULT2) begin
        chk("channel flip", 8'(measChannel), 8'(!prevChan));
      end
    end
    prevStep <= currentStep;
    prevChan <= measChannel;
  end

  function automatic logic [7:0] expInt(input int q, input logic ext);
    int d;
    d = (q >>> 2) + (ext ? 64 : 0);
    if (d < 0) d = 0;
    if (d > (ext ? 255 : 127)) d = ext ? 255 : 127;
    return 8'(d);
  endfunction

  function automatic logic [7:0] expFrac(input int q, input logic ext);
    int d;
    d = (q >>> 2) + (ext ? 64 : 0);
    return (d < 0 || d > (ext ? 255 : 127)) ? 8'h00 : {q[1:0], 6'h00};
  endfunction

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    regReq = '{read: 1'b1, addr: addr};
    @(negedge clock);
    regReq = '0;
    @(negedge clock);
    data = regReadData;
  endtask

  // one local and one remote conversion, front end then idle
  task automatic pair(input int lq, input int rq, input logic sh);
    logic [7:0] goal;
    int         n;
    @(negedge clock);
    localRaw    = RAW_W'(lq);
    remoteRaw   = RAW_W'(rq);
    remoteShort = sh;
    goal        = stepCount + 8'h08;
    run         = 1'b1;
    for (n = 0; n < 200 && stepCount !== goal; n++) @(negedge clock);
    run = 1'b0;
    if (n == 200) begin
      numErrors++;
      $display("BAD conversion wait expected done seen timeout");
      stopTest();
    end
    repeat (12) @(negedge clock);
  endtask

  // fraction first, so the pair comes from one measurement
  task automatic chkRemote(input int q, input logic ext);
    logic [7:0] d;
    rd(ADDR_REM_FRAC, d);
    chk("remote fraction", d, expFrac(q, ext));
    rd(ADDR_REM_INT, d);
    chk("remote integer", d, expInt(q, ext));
  endtask

  task automatic chkLocal(input int q, input logic ext);
    logic [7:0] d;
    rd(ADDR_LOCAL, d);
    chk("local", d, expInt(q, ext));
  endtask

  task automatic tReset();
    logic [7:0] d;
    logic [7:0] a [4];
    a = '{ADDR_LOCAL, ADDR_REM_FRAC, ADDR_REM_INT, 8'h03};
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      chk("reset read", d, (i < 3) ? RESULT_RESET : READ_UNMAPPED);
    end
  endtask

  // fifteen pairs leave results alone; the sixteenth stores the floor mean
  task automatic tAvg();
    @(negedge clock);
    convRateCode = 4'h7;
    for (int i = 0; i < 16; i++) begin
      if (i == 15) begin
        chkLocal(0, 1'b0);
        chkRemote(0, 1'b0);
      end
      pair(164 + 4 * (i % 2), 121 + 2 * (i % 2), 1'b0);
    end
    chkLocal(166, 1'b0);
    chkRemote(122, 1'b0);
    @(negedge clock);
    convRateCode = RATE_NO_AVG;
  endtask

  task automatic tPlain();
    for (int q = 0; q < 4; q++) begin
      pair(103, 40 + q, 1'b0);
      chkLocal(103, 1'b0);
      chkRemote(40 + q, 1'b0);
    end
    pair(-20, 800, 1'b0);
    chkLocal(-20, 1'b0);
    chkRemote(800, 1'b0);
  endtask

  task automatic tLock();
    logic [7:0] d;
    pair(80, 200, 1'b0);
    rd(ADDR_REM_FRAC, d);
    chk("fraction", d, expFrac(200, 1'b0));
    pair(84, 301, 1'b0);
    chkLocal(84, 1'b0);
    rd(ADDR_REM_INT, d);
    chk("locked integer", d, expInt(200, 1'b0));
    pair(84, 301, 1'b0);
    chkRemote(301, 1'b0);
  endtask

  task automatic tShort();
    pair(88, 404, 1'b1);
    chkLocal(88, 1'b0);
    chkRemote(301, 1'b0);
    pair(88, 404, 1'b0);
    chkRemote(404, 1'b0);
  endtask

  // local of the first pair began under the old range
  task automatic tExt();
    @(negedge clock);
    rangeSelect  = 1'b1;
    convRateCode = 4'ha;
    pair(0, -220, 1'b0);
    chkLocal(0, 1'b0);
    chkRemote(-220, 1'b1);
    pair(0, 602, 1'b0);
    chkLocal(0, 1'b1);
    chkRemote(602, 1'b1);
    pair(-400, 1100, 1'b0);
    chkLocal(-400, 1'b1);
    chkRemote(1100, 1'b1);
  endtask

  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    tReset();
    tAvg();
    tPlain();
    tLock();
    tShort();
    tExt();
    stopTest();
  end
endmodule
`default_nettype wire
